/* rtl/rsi_pkg.sv */
package rsi_pkg;

  // register map: printed offsets are bytes, but 0x3a is not a word
  // multiple, so each printed offset is an index and the byte address is
  // four times it
  localparam logic [7:0] SICS_IDX = 8'h3a;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h3b;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h3c;
  localparam logic [7:0] CAUSE_IDX = 8'h3d;
  localparam int ADDR_W = 12;

  // supply_integrity_ctrl_status fields
  localparam int SICS_EWF_BIT = 6;
  localparam int SICS_EWIE_BIT = 5;
  localparam int SICS_DROP_RST_BIT = 4;
  localparam int SICS_WDG_RST_BIT = 3;
  localparam int SICS_ILL_RST_BIT = 2;
  localparam int SICS_EXT_RST_BIT = 1;
  localparam int SICS_EN_BIT = 0;

  // interrupt status / mask bits
  localparam int IRQ_W = 2;
  localparam int IRQ_EW_BIT = 0;
  localparam int IRQ_RST_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int MIN_RESET_OUT_PULSE_NS = 20_000;
  localparam int MIN_RESET_OUT_PULSE_CYC =
    (MIN_RESET_OUT_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PULSE_W = 16;

  typedef enum logic [1:0] {
    rsi_lvl_low = 2'b00,
    rsi_lvl_med = 2'b01,
    rsi_lvl_high = 2'b10
  } rsi_level_t;

  typedef enum logic [1:0] {
    rsi_run = 2'b00,
    rsi_hold = 2'b01,
    rsi_release = 2'b10
  } rsi_state_t;

  // nonvolatile option byte fields
  typedef struct packed {
    logic drop_en;
    rsi_level_t level;
  } rsi_option_t;

  // raw analog comparator outputs, per threshold
  typedef struct packed {
    logic [2:0] drop_rise_below;
    logic [2:0] drop_fall_below;
    logic [2:0] warn_below;
  } rsi_comp_t;

  typedef struct packed {
    logic drop;
    logic wdg;
    logic ill;
    logic ext;
  } rsi_cause_t;

endpackage : rsi_pkg

/* rtl/rsi_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; a change is taken once stages two and three agree
module rsi_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          q[i] <= INIT[i];
        end else if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule : rsi_sync3
`default_nettype wire

/* rtl/rsi_top.sv */
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - enabled drop detector below threshold holds chip in reset until recovery.
// - any drop detector reset drives the reset pin low.
// - rising threshold while powering up, falling threshold once running.
// - watchdog underflow drives reset pin low for the minimum pulse width.
// - illegal opcode or prebyte raises a system reset.
// - external reset pin is asynchronous; it is synchronised before use.
// - option byte enables detector and picks low, medium or high level.
// - early warning flag is real time and read only.
// - early warning works only with the drop detector enabled.
// - early warning threshold follows the configured drop detector level.
// - early warning flag change in either direction requests an interrupt.
module rsi_top #(
  parameter int PULSE_CYC = rsi_pkg::MIN_RESET_OUT_PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rsi_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rsi_pkg::rsi_option_t option,
  input wire rsi_pkg::rsi_comp_t comp,
  input wire logic wdg_underflow,
  input wire logic illegal_op,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  output logic sys_reset,
  output logic irq
);

  logic [2:0] rise_s;
  logic [2:0] fall_s;
  logic [2:0] warn_s;
  logic ext_n_s;
  logic powered;
  logic drop_rst;
  logic [rsi_pkg::PULSE_W-1:0] pulse_cnt;
  logic wdg_rst;
  logic ill_rst;
  rsi_pkg::rsi_state_t state;
  rsi_pkg::rsi_state_t next_state;
  logic any_src;
  logic ew_flag;
  logic ew_prev;
  logic ew_ie;
  logic [rsi_pkg::IRQ_W-1:0] irq_stat;
  logic [rsi_pkg::IRQ_W-1:0] irq_mask;
  rsi_pkg::rsi_cause_t cause;
  logic [2:0] lvl_sel;
  logic acc;
  logic wr;
  logic [7:0] idx;
  logic hit;
  logic [31:0] next_rdata;
  logic [7:0] sics_val;
  logic ew_evt;
  logic rst_evt;
  // pin echo window: synchroniser depth plus the agree stage
  localparam int ECHO_CYC = 4;
  logic [ECHO_CYC-1:0] drv_hist;
  logic own_echo;
  logic clr_sics;

  function automatic logic [2:0] level_onehot(
    input rsi_pkg::rsi_level_t lv
  );
    case (lv)
      rsi_pkg::rsi_lvl_low: level_onehot = 3'h1;
      rsi_pkg::rsi_lvl_med: level_onehot = 3'h2;
      rsi_pkg::rsi_lvl_high: level_onehot = 3'h4;
      default: level_onehot = 3'h4;
    endcase
  endfunction : level_onehot

  function automatic logic idx_hit(input logic [7:0] i);
    idx_hit = (i == rsi_pkg::SICS_IDX) || (i == rsi_pkg::IRQ_STAT_IDX) ||
      (i == rsi_pkg::IRQ_MASK_IDX) || (i == rsi_pkg::CAUSE_IDX);
  endfunction : idx_hit

  rsi_sync3 #(.W(1), .INIT(1'b0)) u_ext (
    .clk(pclk),
    .rst_n(presetn),
    .d(reset_pin_in),
    .q(ext_n_s)
  );

  // comparators are analog and asynchronous to pclk; start as below
  rsi_sync3 #(.W(9), .INIT(9'h1ff)) u_comp (
    .clk(pclk),
    .rst_n(presetn),
    .d(comp),
    .q({rise_s, fall_s, warn_s})
  );

  // one level select serves both detectors
  assign lvl_sel = level_onehot(option.level);

  // rising threshold until power is up, then falling threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powered <= 1'b0;
    end else if (!option.drop_en) begin
      powered <= 1'b1;
    end else if (powered) begin
      powered <= !(|(fall_s & lvl_sel));
    end else begin
      powered <= !(|(rise_s & lvl_sel));
    end
  end

  // static reset while below the active threshold
  assign drop_rst = option.drop_en && !powered;

  // watchdog pulse, restarted by every underflow
  // PULSE_W bounds the longest pulse; widen it for faster clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt <= '0;
    end else if (wdg_underflow) begin
      pulse_cnt <= rsi_pkg::PULSE_W'(PULSE_CYC);
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 1'b1;
    end
  end
  assign wdg_rst = (pulse_cnt != '0);

  // illegal code latched for one cycle, then held by the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ill_rst <= 1'b0;
    end else begin
      ill_rst <= illegal_op;
    end
  end

  assign any_src = drop_rst || wdg_rst || ill_rst || !ext_n_s;

  // release gives one settled edge before run; a source that returns
  // there goes straight back to hold
  always_comb begin
    next_state = state;
    case (state)
      rsi_pkg::rsi_run: begin
        if (any_src) begin
          next_state = rsi_pkg::rsi_hold;
        end
      end
      rsi_pkg::rsi_hold: begin
        if (!any_src) begin
          next_state = rsi_pkg::rsi_release;
        end
      end
      rsi_pkg::rsi_release: begin
        next_state = any_src ? rsi_pkg::rsi_hold : rsi_pkg::rsi_run;
      end
      default: next_state = rsi_pkg::rsi_hold;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= rsi_pkg::rsi_hold;
    end else begin
      state <= next_state;
    end
  end

  // registered system reset, released two edges after the sources clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset <= 1'b1;
    end else begin
      sys_reset <= (next_state != rsi_pkg::rsi_run);
    end
  end

  // pin driven low for internal sources; oe_n low while driving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= 1'b0;
    end else begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= !(drop_rst || wdg_rst || ill_rst);
    end
  end

  // with the detector off, the board holds the pin; ext path covers it
  // real-time flag, silent when the detector is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ew_flag <= 1'b0;
      ew_prev <= 1'b0;
    end else begin
      ew_flag <= option.drop_en && (|(warn_s & lvl_sel));
      ew_prev <= ew_flag;
    end
  end

  // the flag may rise just after reset; ew_ie resets low so no false event
  // either edge of the flag is an event
  assign ew_evt = (ew_flag != ew_prev) && ew_ie;
  assign rst_evt = (state == rsi_pkg::rsi_release) && !any_src;

  // apb: zero-wait; writes decode in access phase, reads and pslverr in setup
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign idx = paddr[$bits(idx)+1:2];
  // address bits above the index must be zero, or the access is refused
  assign hit = idx_hit(idx) && (paddr[1:0] == 2'b00) &&
    (paddr[rsi_pkg::ADDR_W-1:$bits(idx)+2] == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ew_ie <= 1'b0;
      irq_mask <= rsi_pkg::IRQ_MASK_RST;
    end else if (wr && hit && pstrb[0]) begin
      if (idx == rsi_pkg::SICS_IDX) begin
        ew_ie <= pwdata[rsi_pkg::SICS_EWIE_BIT];
      end
      if (idx == rsi_pkg::IRQ_MASK_IDX) begin
        irq_mask <= pwdata[rsi_pkg::IRQ_W-1:0];
      end
    end
  end

  // sticky status; a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      for (int i = 0; i < rsi_pkg::IRQ_W; i++) begin
        if ((i == rsi_pkg::IRQ_EW_BIT && ew_evt) ||
            (i == rsi_pkg::IRQ_RST_BIT && rst_evt)) begin
          irq_stat[i] <= 1'b1;
        end else if (wr && hit && idx == rsi_pkg::IRQ_STAT_IDX && pstrb[0] &&
                     pwdata[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      // masking hides an event but keeps it pending in the status
      irq <= |(irq_stat & irq_mask);
    end
  end

  // after we stop driving, the pin still reads low through the
  // synchroniser for a few edges; that echo is not an external reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_hist <= '1;
    end else begin
      drv_hist <= {drv_hist[ECHO_CYC-2:0], !reset_pin_oe_n};
    end
  end

  assign own_echo = |drv_hist;
  assign clr_sics = wr && hit && pstrb[0] && (idx == rsi_pkg::SICS_IDX);

  // cause flags latch during reset, clear by writing one to the bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause <= '0;
    end else begin
      if (drop_rst) begin
        cause.drop <= 1'b1;
      end else if (clr_sics && pwdata[rsi_pkg::SICS_DROP_RST_BIT]) begin
        cause.drop <= 1'b0;
      end
      if (wdg_rst) begin
        cause.wdg <= 1'b1;
      end else if (clr_sics && pwdata[rsi_pkg::SICS_WDG_RST_BIT]) begin
        cause.wdg <= 1'b0;
      end
      if (ill_rst) begin
        cause.ill <= 1'b1;
      end else if (clr_sics && pwdata[rsi_pkg::SICS_ILL_RST_BIT]) begin
        cause.ill <= 1'b0;
      end
      if (!ext_n_s && reset_pin_oe_n && !own_echo) begin
        cause.ext <= 1'b1;
      end else if (clr_sics && pwdata[rsi_pkg::SICS_EXT_RST_BIT]) begin
        cause.ext <= 1'b0;
      end
    end
  end

  always_comb begin
    sics_val = 8'h00;
    sics_val[rsi_pkg::SICS_EWF_BIT] = ew_flag;
    sics_val[rsi_pkg::SICS_EWIE_BIT] = ew_ie;
    sics_val[rsi_pkg::SICS_DROP_RST_BIT] = cause.drop;
    sics_val[rsi_pkg::SICS_WDG_RST_BIT] = cause.wdg;
    sics_val[rsi_pkg::SICS_ILL_RST_BIT] = cause.ill;
    sics_val[rsi_pkg::SICS_EXT_RST_BIT] = cause.ext;
    sics_val[rsi_pkg::SICS_EN_BIT] = option.drop_en;
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (idx)
      rsi_pkg::SICS_IDX: next_rdata[7:0] = sics_val;
      rsi_pkg::IRQ_STAT_IDX: next_rdata[rsi_pkg::IRQ_W-1:0] = irq_stat;
      rsi_pkg::IRQ_MASK_IDX: next_rdata[rsi_pkg::IRQ_W-1:0] = irq_mask;
      rsi_pkg::CAUSE_IDX: next_rdata[3:0] = cause;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data registered in setup so it stands at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (psel && !penable && !pwrite) begin
        // unmapped or misaligned reads return zero
        prdata <= hit ? next_rdata : 32'h0000_0000;
      end
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end

endmodule : rsi_top
`default_nettype wire

/* testbench/rsi_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module rsi_chk #(
  parameter int PULSE_CYC = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire rsi_pkg::rsi_option_t option,
  input wire rsi_pkg::rsi_comp_t comp,
  input wire logic wdg_underflow,
  input wire logic illegal_op,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  input wire logic sys_reset
);
  logic drop_below;
  assign drop_below = option.drop_en && comp.drop_fall_below[option.level]
    && comp.drop_rise_below[option.level];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_wdg_pulse: assert property (
    wdg_underflow |-> ##2 (!reset_pin_oe_n) [*8])
    else $error("pin pulse short");
  chk_wdg_sys: assert property (
    wdg_underflow |-> ##2 sys_reset) else $error("no reset on underflow");
  chk_ill_rst: assert property (
    illegal_op |-> ##2 sys_reset [*2]) else $error("no reset on opcode");
  chk_pin_low: assert property (
    !reset_pin_oe_n |-> !reset_pin_out && sys_reset)
    else $error("pin driven wrongly");
  chk_drop_rst: assert property (
    drop_below [*8] |=> sys_reset && !reset_pin_oe_n)
    else $error("no reset on drop");
  chk_ext_rst: assert property (
    !reset_pin_in [*8] |=> sys_reset) else $error("pin reset missed");
  chk_rel_sync: assert property (
    $fell(sys_reset) |-> reset_pin_oe_n && $past(reset_pin_oe_n))
    else $error("early release");
  chk_apb_zero: assert property (
    psel && !penable |=> pready) else $error("wait state seen");
endmodule : rsi_chk
bind rsi_top rsi_chk #(.PULSE_CYC(PULSE_CYC)) u_rsi_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .option(option), .comp(comp), .wdg_underflow(wdg_underflow),
  .illegal_op(illegal_op), .reset_pin_in(reset_pin_in),
  .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
  .sys_reset(sys_reset));
`default_nettype wire

/* testbench/rsi_board.sv */
`timescale 1ns/1ps
`default_nettype none
module rsi_board (
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  input wire logic drop_en,
  input wire logic supply_ok,
  input wire logic push,
  output logic reset_pin_in
);
  // pulled up; low while anyone pulls it down
  // with the detector off, hold low until supply ok
  assign reset_pin_in = !((!reset_pin_oe_n && !reset_pin_out) || push ||
    (!drop_en && !supply_ok));
endmodule : rsi_board
`default_nettype wire

/* testbench/reset_and_supply_integrity_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_and_supply_integrity_bench;
  localparam int PULSE = 8;
  localparam logic [7:0] SI = rsi_pkg::SICS_IDX;
  localparam logic [7:0] MI = rsi_pkg::IRQ_MASK_IDX;
  logic pclk, presetn, psel, penable, pwrite, wdg, ill, push, ok;
  logic pready, pslverr, pin_in, pin_out, oe_n, sys_reset, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0] pstrb;
  rsi_pkg::rsi_option_t option;
  rsi_pkg::rsi_comp_t comp;
  int miscompares, cmp_count, cyc;
  rsi_top #(.PULSE_CYC(PULSE)) u_rsi_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .option(option), .comp(comp),
    .wdg_underflow(wdg), .illegal_op(ill), .reset_pin_in(pin_in),
    .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n),
    .sys_reset(sys_reset), .irq(irq));
  rsi_board u_rsi_board (.reset_pin_out(pin_out), .reset_pin_oe_n(oe_n),
    .drop_en(option.drop_en), .supply_ok(ok), .push(push),
    .reset_pin_in(pin_in));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  task final_report;
    $display("mismatches %0d of %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] idx,
    input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // sys_reset may hold registers; the global cycle limit bounds this
  task automatic settle;
    while (sys_reset !== 1'b0) @(posedge pclk);
    apb(1'b0, SI, 8'h0);
  endtask : settle
  task automatic s_regs;
    settle;
    chk(d & 32'hffffff5f, 32'h11);
    apb(1'b0, MI, 8'h0);
    chk(d, 32'h0);
    apb(1'b0, 8'h3e, 8'h0);
    chk({err, d[30:0]}, 32'h80000000);
    apb(1'b1, SI, 8'h1e);
  endtask : s_regs
  task automatic s_wdg;
    int n;
    n = 0;
    wdg <= 1'b1;
    @(posedge pclk);
    wdg <= 1'b0;
    @(posedge pclk);
    // registered outputs are read between edges, where they have settled
    @(negedge pclk);
    while (oe_n === 1'b0 && n < 100) begin
      n++;
      @(negedge pclk);
    end
    chk(n, PULSE);
    settle;
    chk(d & 32'h1e, 32'h08);
    apb(1'b1, SI, 8'h1e);
    ill <= 1'b1;
    @(posedge pclk);
    ill <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    chk(sys_reset, 1'b1);
    settle;
    chk(d & 32'h1e, 32'h04);
    apb(1'b1, SI, 8'h1e);
  endtask : s_wdg
  task automatic s_ext;
    push <= 1'b1;
    repeat (12) @(posedge pclk);
    chk({sys_reset, oe_n}, 2'b11);
    push <= 1'b0;
    settle;
    chk(d & 32'h1e, 32'h02);
    apb(1'b1, SI, 8'h1e);
  endtask : s_ext
  task automatic s_drop;
    comp.drop_rise_below <= 3'b111;
    comp.drop_fall_below <= 3'b100;
    repeat (12) @(posedge pclk);
    chk(sys_reset, 1'b0);
    comp.drop_fall_below <= 3'b110;
    repeat (12) @(posedge pclk);
    chk({sys_reset, oe_n}, 2'b10);
    comp.drop_fall_below <= 3'b000;
    repeat (12) @(posedge pclk);
    chk({sys_reset, oe_n}, 2'b10);
    comp.drop_rise_below <= 3'b000;
    settle;
    chk(d & 32'h1e, 32'h10);
    apb(1'b1, SI, 8'h1e);
  endtask : s_drop
  task automatic s_warn;
    apb(1'b1, SI, 8'h20);
    apb(1'b1, MI, 8'h01);
    comp.warn_below <= 3'b100;
    repeat (10) @(posedge pclk);
    apb(1'b0, SI, 8'h0);
    chk({irq, d[6]}, 2'b00);
    comp.warn_below <= 3'b110;
    repeat (10) @(posedge pclk);
    apb(1'b1, SI, 8'h20);
    apb(1'b0, SI, 8'h0);
    chk({irq, d[6]}, 2'b11);
    apb(1'b1, rsi_pkg::IRQ_STAT_IDX, 8'h01);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    comp.warn_below <= 3'b000;
    repeat (10) @(posedge pclk);
    apb(1'b0, SI, 8'h0);
    chk({irq, d[6]}, 2'b10);
    apb(1'b1, MI, 8'h00);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
  endtask : s_warn
  task automatic s_off;
    option.drop_en <= 1'b0;
    ok <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    comp <= '1;
    repeat (20) @(posedge pclk);
    chk(sys_reset, 1'b1);
    ok <= 1'b1;
    settle;
    apb(1'b1, SI, 8'h20);
    apb(1'b1, MI, 8'h01);
    comp.warn_below <= 3'b000;
    repeat (10) @(posedge pclk);
    apb(1'b0, SI, 8'h0);
    chk({irq, d[6], d[0]}, 3'b000);
  endtask : s_off
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h1;
    wdg = 1'b0;
    ill = 1'b0;
    push = 1'b0;
    ok = 1'b1;
    comp = '0;
    option.drop_en = 1'b1;
    option.level = rsi_pkg::rsi_lvl_med;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_wdg();
    s_ext();
    s_drop();
    s_warn();
    s_off();
    final_report();
  end
endmodule : reset_and_supply_integrity_bench
`default_nettype wire
